// >>> src/pcip_port.sv
// pci initiator and target signalling for the bridge
`timescale 1ns/10ps
module pcip_port (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // multiplexed address/data and command/byte enables
    input  wire logic [31:0] ad_in,
    output logic [31:0]      ad_out_q,
    output logic             ad_oe_q,
    input  wire logic [3:0]  cbe_n_in,
    output logic [3:0]       cbe_n_out_q,
    output logic             cbe_n_oe_q,
    // framing and handshakes
    input  wire logic        frame_n_in,
    output logic             frame_n_out_q,
    output logic             frame_n_oe_q,
    input  wire logic        irdy_n_in,
    output logic             irdy_n_out_q,
    output logic             irdy_n_oe_q,
    input  wire logic        trdy_n_in,
    output logic             trdy_n_out_q,
    output logic             trdy_n_oe_q,
    input  wire logic        devsel_n_in,
    output logic             devsel_n_out_q,
    output logic             devsel_n_oe_q,
    input  wire logic        bus_lock_n_in,
    output logic             bus_lock_n_out_q,
    output logic             bus_lock_n_oe_q,
    output logic             par_out_q,
    output logic             par_oe_q,
    // grant and config select
    input  wire logic        gnt_n,
    input  wire logic        idsel,
    // initiator user side
    input  wire logic        ini_req,
    input  wire logic [3:0]  ini_cmd,
    input  wire logic [31:0] ini_addr,
    input  wire logic [31:0] ini_wdata,
    input  wire logic [3:0]  ini_be_n,
    input  wire logic        ini_lock,
    output logic             ini_busy_q,
    output logic             ini_done_q,
    output logic             ini_abort_q,
    output logic [31:0]      ini_rdata_q,
    output logic             ini_lock_own_q,
    // target user side
    input  wire logic [31:0] dram_base,
    input  wire logic [31:0] dram_limit,
    input  wire logic [31:0] tgt_rdata,
    output logic             tgt_wr_q,
    output logic             tgt_rd_q,
    output logic             tgt_cfg_q,
    output logic [31:0]      tgt_addr_q,
    output logic [31:0]      tgt_wdata_q,
    output logic [3:0]       tgt_be_n_q
);
    pcip_pkg::pcip_ini_st_t ini_st_q, ini_st_d;
    pcip_pkg::pcip_tgt_st_t tgt_st_q, tgt_st_d;
    logic [3:0]  ini_cmd_q, ini_cmd_d, ini_be_n_q, ini_be_n_d, tgt_cmd_q, tgt_cmd_d;
    logic [31:0] ini_wdata_q, ini_wdata_d, ini_rdata_d, ad_out_d, tgt_addr_d, tgt_wdata_d;
    logic [3:0]  cbe_n_out_d, tgt_be_n_d;
    logic [2:0]  abort_cnt_q, abort_cnt_d;
    logic        ini_lock_q, ini_lock_d, frame_prev_q, frame_prev_d;
    logic        ad_oe_d, cbe_n_oe_d, frame_n_out_d, frame_n_oe_d, irdy_n_out_d, irdy_n_oe_d;
    logic        trdy_n_out_d, trdy_n_oe_d, devsel_n_out_d, devsel_n_oe_d;
    logic        bus_lock_n_out_d, bus_lock_n_oe_d, ini_lock_own_d;
    logic        ini_busy_d, ini_done_d, ini_abort_d, tgt_wr_d, tgt_rd_d, tgt_cfg_d;
    logic        addr_phase, tgt_hit, lock_free, tgt_write;
    logic [3:0]  par_cbe;

    // a new address phase is the first cycle of framing low
    assign addr_phase = !frame_n_in && frame_prev_q && (ini_st_q == pcip_pkg::I_IDLE);
    assign lock_free  = bus_lock_n_in || ini_lock_own_q;
    assign tgt_write  = pcip_pkg::cmd_is_write(tgt_cmd_q);
    assign tgt_hit    = !pcip_pkg::cmd_is_reserved(cbe_n_in)
        && ((pcip_pkg::cmd_is_mem(cbe_n_in) && (ad_in >= dram_base) && (ad_in <= dram_limit))
        || (pcip_pkg::cmd_is_cfg(cbe_n_in) && idsel && (ad_in[1:0] == pcip_pkg::CFG_TYPE0)));
    // on target reads the initiator owns the byte enables
    assign par_cbe = cbe_n_oe_q ? cbe_n_out_q : cbe_n_in;

    always_comb begin
        ini_st_d = ini_st_q; tgt_st_d = tgt_st_q;
        ini_cmd_d = ini_cmd_q; ini_be_n_d = ini_be_n_q; ini_wdata_d = ini_wdata_q;
        ini_lock_d = ini_lock_q; ini_rdata_d = ini_rdata_q; abort_cnt_d = abort_cnt_q;
        tgt_cmd_d = tgt_cmd_q; tgt_addr_d = tgt_addr_q; tgt_wdata_d = tgt_wdata_q;
        tgt_be_n_d = tgt_be_n_q; tgt_cfg_d = tgt_cfg_q;
        frame_prev_d = frame_n_in;
        ad_out_d = ad_out_q; ad_oe_d = 1'b0;
        cbe_n_out_d = cbe_n_out_q; cbe_n_oe_d = cbe_n_oe_q;
        frame_n_out_d = frame_n_out_q; frame_n_oe_d = frame_n_oe_q;
        irdy_n_out_d = irdy_n_out_q; irdy_n_oe_d = irdy_n_oe_q;
        trdy_n_out_d = trdy_n_out_q; trdy_n_oe_d = trdy_n_oe_q;
        devsel_n_out_d = devsel_n_out_q; devsel_n_oe_d = devsel_n_oe_q;
        bus_lock_n_out_d = bus_lock_n_out_q; bus_lock_n_oe_d = bus_lock_n_oe_q;
        ini_lock_own_d = ini_lock_own_q; ini_busy_d = ini_busy_q;
        ini_done_d = 1'b0; ini_abort_d = 1'b0; tgt_wr_d = 1'b0; tgt_rd_d = 1'b0;

        case (ini_st_q)
            pcip_pkg::I_IDLE: begin
                // drive lock high on release, then float it on the next clock spent in idle
                if (ini_lock_own_q && !ini_lock) begin
                    bus_lock_n_out_d = pcip_pkg::PIN_IDLE;
                    ini_lock_own_d   = 1'b0;
                end else if (!ini_lock_own_q) begin
                    bus_lock_n_oe_d = 1'b0;
                end
                // on a locked request the grant only starts us if the lock is also ours to take
                if (ini_req && !gnt_n && frame_n_in && irdy_n_in && (tgt_st_q == pcip_pkg::T_IDLE)
                        && (!ini_lock || lock_free)) begin
                    ini_st_d      = pcip_pkg::I_ADDR;
                    ini_cmd_d     = ini_cmd;
                    ini_be_n_d    = ini_be_n;
                    ini_wdata_d   = ini_wdata;
                    ini_lock_d    = ini_lock;
                    ini_busy_d    = 1'b1;
                    frame_n_out_d = 1'b0;
                    frame_n_oe_d  = 1'b1;
                    ad_out_d      = ini_addr;
                    ad_oe_d       = 1'b1;
                    cbe_n_out_d   = ini_cmd;
                    cbe_n_oe_d    = 1'b1;
                end
            end
            pcip_pkg::I_ADDR: begin
                // single data phase: framing goes high with initiator-ready low
                ini_st_d      = pcip_pkg::I_DATA;
                frame_n_out_d = pcip_pkg::PIN_IDLE;
                irdy_n_out_d  = 1'b0;
                irdy_n_oe_d   = 1'b1;
                cbe_n_out_d   = ini_be_n_q;
                ad_out_d      = ini_wdata_q;
                ad_oe_d       = pcip_pkg::cmd_is_write(ini_cmd_q);
                abort_cnt_d   = pcip_pkg::CNT_RST;
                if (ini_lock_q) begin
                    bus_lock_n_out_d = 1'b0;
                    bus_lock_n_oe_d  = 1'b1;
                    ini_lock_own_d   = 1'b1;
                end
            end
            pcip_pkg::I_DATA: begin
                ad_oe_d = pcip_pkg::cmd_is_write(ini_cmd_q);
                if (!trdy_n_in) begin
                    ini_st_d    = pcip_pkg::I_TURN;
                    ini_rdata_d = ad_in;
                    ini_done_d  = 1'b1;
                end else if (devsel_n_in && (abort_cnt_q == pcip_pkg::ABORT_CYC)) begin
                    // nobody claimed the cycle: master abort
                    ini_st_d    = pcip_pkg::I_TURN;
                    ini_done_d  = 1'b1;
                    ini_abort_d = 1'b1;
                end else if (devsel_n_in) begin
                    abort_cnt_d = 3'(abort_cnt_q + 3'h1);
                end
                if (ini_st_d == pcip_pkg::I_TURN) begin
                    ad_oe_d      = 1'b0;
                    irdy_n_out_d = pcip_pkg::PIN_IDLE;
                    frame_n_oe_d = 1'b0;
                    cbe_n_oe_d   = 1'b0;
                end
            end
            pcip_pkg::I_TURN: begin
                ini_st_d    = pcip_pkg::I_IDLE;
                irdy_n_oe_d = 1'b0;
                ini_busy_d  = 1'b0;
            end
            default: ini_st_d = pcip_pkg::I_IDLE;
        endcase

        case (tgt_st_q)
            pcip_pkg::T_IDLE: begin
                if (addr_phase && tgt_hit) begin
                    tgt_st_d       = pcip_pkg::T_DEVSEL;
                    tgt_cmd_d      = cbe_n_in;
                    tgt_cfg_d      = pcip_pkg::cmd_is_cfg(cbe_n_in);
                    tgt_addr_d     = {ad_in[31:2], 2'b00};
                    devsel_n_out_d = 1'b0;
                    devsel_n_oe_d  = 1'b1;
                    trdy_n_out_d   = pcip_pkg::PIN_IDLE;
                    trdy_n_oe_d    = 1'b1;
                end
            end
            pcip_pkg::T_DEVSEL: begin
                // one wait clock: bus turnaround or next read word fetch
                tgt_st_d     = pcip_pkg::T_DATA;
                trdy_n_out_d = 1'b0;
                ad_out_d     = tgt_rdata;
                ad_oe_d      = !tgt_write;
                if (tgt_wr_q) begin
                    tgt_addr_d = tgt_addr_q + pcip_pkg::ADDR_STEP;
                end
            end
            pcip_pkg::T_DATA: begin
                ad_oe_d = !tgt_write;
                if (!irdy_n_in) begin
                    if (tgt_write) begin
                        tgt_wdata_d = ad_in;
                        tgt_be_n_d  = cbe_n_in;
                        tgt_wr_d    = 1'b1;
                    end else begin
                        tgt_rd_d = 1'b1;
                    end
                    if (!frame_n_in) begin
                        tgt_st_d     = pcip_pkg::T_DEVSEL;
                        trdy_n_out_d = pcip_pkg::PIN_IDLE;
                        if (!tgt_write) begin
                            tgt_addr_d = tgt_addr_q + pcip_pkg::ADDR_STEP;
                        end
                    end else begin
                        tgt_st_d       = pcip_pkg::T_TURN;
                        trdy_n_out_d   = pcip_pkg::PIN_IDLE;
                        devsel_n_out_d = pcip_pkg::PIN_IDLE;
                        ad_oe_d        = 1'b0;
                    end
                end
            end
            pcip_pkg::T_TURN: begin
                tgt_st_d      = pcip_pkg::T_IDLE;
                trdy_n_oe_d   = 1'b0;
                devsel_n_oe_d = 1'b0;
            end
            default: tgt_st_d = pcip_pkg::T_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ini_st_q <= pcip_pkg::I_IDLE;     tgt_st_q <= pcip_pkg::T_IDLE;
            ini_cmd_q <= pcip_pkg::CBE_RST;   ini_be_n_q <= pcip_pkg::CBE_RST;
            ini_wdata_q <= pcip_pkg::AD_RST;  ini_rdata_q <= pcip_pkg::AD_RST;
            ini_lock_q <= 1'b0;               abort_cnt_q <= pcip_pkg::CNT_RST;
            tgt_cmd_q <= pcip_pkg::CBE_RST;   tgt_addr_q <= pcip_pkg::AD_RST;
            tgt_wdata_q <= pcip_pkg::AD_RST;  tgt_be_n_q <= pcip_pkg::CBE_RST;
            tgt_cfg_q <= 1'b0;                frame_prev_q <= pcip_pkg::PIN_IDLE;
            ad_out_q <= pcip_pkg::AD_RST;     ad_oe_q <= 1'b0;
            cbe_n_out_q <= pcip_pkg::CBE_RST; cbe_n_oe_q <= 1'b0;
            frame_n_out_q <= pcip_pkg::PIN_IDLE;    frame_n_oe_q <= 1'b0;
            irdy_n_out_q <= pcip_pkg::PIN_IDLE;     irdy_n_oe_q <= 1'b0;
            trdy_n_out_q <= pcip_pkg::PIN_IDLE;     trdy_n_oe_q <= 1'b0;
            devsel_n_out_q <= pcip_pkg::PIN_IDLE;   devsel_n_oe_q <= 1'b0;
            bus_lock_n_out_q <= pcip_pkg::PIN_IDLE; bus_lock_n_oe_q <= 1'b0;
            ini_lock_own_q <= 1'b0;           ini_busy_q <= 1'b0;
            ini_done_q <= 1'b0;               ini_abort_q <= 1'b0;
            tgt_wr_q <= 1'b0;                 tgt_rd_q <= 1'b0;
        end else begin
            ini_st_q <= ini_st_d;             tgt_st_q <= tgt_st_d;
            ini_cmd_q <= ini_cmd_d;           ini_be_n_q <= ini_be_n_d;
            ini_wdata_q <= ini_wdata_d;       ini_rdata_q <= ini_rdata_d;
            ini_lock_q <= ini_lock_d;         abort_cnt_q <= abort_cnt_d;
            tgt_cmd_q <= tgt_cmd_d;           tgt_addr_q <= tgt_addr_d;
            tgt_wdata_q <= tgt_wdata_d;       tgt_be_n_q <= tgt_be_n_d;
            tgt_cfg_q <= tgt_cfg_d;           frame_prev_q <= frame_prev_d;
            ad_out_q <= ad_out_d;             ad_oe_q <= ad_oe_d;
            cbe_n_out_q <= cbe_n_out_d;       cbe_n_oe_q <= cbe_n_oe_d;
            frame_n_out_q <= frame_n_out_d;   frame_n_oe_q <= frame_n_oe_d;
            irdy_n_out_q <= irdy_n_out_d;     irdy_n_oe_q <= irdy_n_oe_d;
            trdy_n_out_q <= trdy_n_out_d;     trdy_n_oe_q <= trdy_n_oe_d;
            devsel_n_out_q <= devsel_n_out_d; devsel_n_oe_q <= devsel_n_oe_d;
            bus_lock_n_out_q <= bus_lock_n_out_d; bus_lock_n_oe_q <= bus_lock_n_oe_d;
            ini_lock_own_q <= ini_lock_own_d; ini_busy_q <= ini_busy_d;
            ini_done_q <= ini_done_d;         ini_abort_q <= ini_abort_d;
            tgt_wr_q <= tgt_wr_d;             tgt_rd_q <= tgt_rd_d;
        end
    end

    pcip_par_gen u_par (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .ad        (ad_out_q),
        .cbe_n     (par_cbe),
        .drive     (ad_oe_q),
        .par_out_q (par_out_q),
        .par_oe_q  (par_oe_q)
    );

    a_devsel_on_hit:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tgt_st_q == pcip_pkg::T_IDLE && addr_phase && tgt_hit)
        |=> (!devsel_n_out_q && devsel_n_oe_q) [*2])
    else $error("hit not claimed with device select");

    a_reserved_ignored:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tgt_st_q == pcip_pkg::T_IDLE && addr_phase && pcip_pkg::cmd_is_reserved(cbe_n_in))
        |=> (tgt_st_q == pcip_pkg::T_IDLE && !devsel_n_oe_q))
    else $error("reserved command was claimed");

    a_frame_addr:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ini_st_q == pcip_pkg::I_ADDR) |-> (!frame_n_out_q && frame_n_oe_q && ad_oe_q
        && ad_out_q == $past(ini_addr) && cbe_n_out_q == ini_cmd_q))
    else $error("address phase not framed with address and command");

    a_irdy_roles:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ini_st_q == pcip_pkg::I_DATA) |-> (irdy_n_oe_q && !irdy_n_out_q && !trdy_n_oe_q))
    else $error("initiator-ready wrong while initiator");

    a_trdy_complete:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ini_st_q == pcip_pkg::I_DATA && !trdy_n_in)
        |=> (ini_done_q && !ini_abort_q && ini_rdata_q == $past(ad_in)) ##1 !ini_busy_q)
    else $error("target-ready did not complete data phase");

    a_byte_enables:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(ini_busy_q) |=> (cbe_n_oe_q && cbe_n_out_q == ini_be_n_q && !irdy_n_out_q))
    else $error("byte enables not shown in data phase");

    a_lock_gated:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ini_st_q == pcip_pkg::I_IDLE && ini_req && !gnt_n && ini_lock
        && !bus_lock_n_in && !ini_lock_own_q) |=> (ini_st_q == pcip_pkg::I_IDLE))
    else $error("lock taken on grant alone");

    a_lock_held:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ini_lock_own_q && ini_lock)
        |=> (ini_lock_own_q && bus_lock_n_oe_q && !bus_lock_n_out_q))
    else $error("held lock dropped early");

    a_mwi_decode:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tgt_st_q == pcip_pkg::T_IDLE && addr_phase && tgt_hit
        && cbe_n_in == pcip_pkg::CMD_MEM_WR_INV)
        |=> (tgt_cmd_q == pcip_pkg::CMD_MEM_WR_INV && tgt_write && !tgt_cfg_q))
    else $error("memory write and invalidate misdecoded");

endmodule

// >>> src/pcip_pkg.sv
// constants, types and command decoding for the pci initiator/target port
// Contract
// - claim a cycle with device select for dram range hits or own config cycles
// - as initiator, drive framing low to mark start and duration of access
// - drive initiator-ready as initiator, sample it as target
// - sample target-ready as initiator, drive it as target
// - support exclusive lock across transactions, non-locked transactions still proceed
// - a grant alone does not win the lock; lock must be free too
// - command on command/byte-enable lines in address phase, decoded there
// - in data phases the same lines carry active-low byte enables
// - code all-ones is memory write and invalidate, both ways
// - address driven with framing, data in the following cycles
// - even parity over address/data and command/byte-enable lines when driven
package pcip_pkg;

    localparam logic [3:0] CMD_INT_ACK     = 4'h0;
    localparam logic [3:0] CMD_SPECIAL     = 4'h1;
    localparam logic [3:0] CMD_IO_RD       = 4'h2;
    localparam logic [3:0] CMD_IO_WR       = 4'h3;
    localparam logic [3:0] CMD_MEM_RD      = 4'h6;
    localparam logic [3:0] CMD_MEM_WR      = 4'h7;
    localparam logic [3:0] CMD_CFG_RD      = 4'hA;
    localparam logic [3:0] CMD_CFG_WR      = 4'hB;
    localparam logic [3:0] CMD_MEM_RD_MUL  = 4'hC;
    localparam logic [3:0] CMD_DUAL_ADDR   = 4'hD;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
    localparam logic [3:0] CMD_MEM_WR_INV  = 4'hF;

    localparam logic        PIN_IDLE   = 1'b1;
    localparam logic [3:0]  CBE_RST    = 4'hF;
    localparam logic [31:0] AD_RST     = 32'h0000_0000;
    localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;
    localparam logic [1:0]  CFG_TYPE0  = 2'h0;
    localparam logic [2:0]  ABORT_CYC  = 3'h5;
    localparam logic [2:0]  CNT_RST    = 3'h0;

    typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA, I_TURN} pcip_ini_st_t;
    typedef enum logic [1:0] {T_IDLE, T_DEVSEL, T_DATA, T_TURN} pcip_tgt_st_t;

    function automatic logic cmd_is_reserved(input logic [3:0] c);
        return (c == 4'h4) || (c == 4'h5) || (c == 4'h8) || (c == 4'h9);
    endfunction

    function automatic logic cmd_is_mem(input logic [3:0] c);
        return (c == CMD_MEM_RD) || (c == CMD_MEM_WR) || (c == CMD_MEM_RD_MUL)
            || (c == CMD_MEM_RD_LINE) || (c == CMD_MEM_WR_INV);
    endfunction

    function automatic logic cmd_is_cfg(input logic [3:0] c);
        return (c == CMD_CFG_RD) || (c == CMD_CFG_WR);
    endfunction

    // every write-type code is odd, reads are even
    function automatic logic cmd_is_write(input logic [3:0] c);
        return c[0];
    endfunction

endpackage

// >>> src/pcip_par_gen.sv
// registered even parity for the address/data and command/byte-enable lines
`timescale 1ns/10ps
module pcip_par_gen (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // lines of the previous cycle
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe_n,
    input  wire logic        drive,
    // parity pin
    output logic             par_out_q,
    output logic             par_oe_q
);
    logic par_d;
    logic par_oe_d;

    // parity trails its data by one clock
    always_comb begin
        par_d    = ^{ad, cbe_n};
        par_oe_d = drive;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            par_out_q <= 1'b0;
            par_oe_q  <= 1'b0;
        end else begin
            par_out_q <= par_d;
            par_oe_q  <= par_oe_d;
        end
    end

    a_parity_even:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
        drive |=> (par_oe_q && ((par_out_q ^ (^{$past(ad), $past(cbe_n)})) == 1'b0)))
    else $error("parity not even over previous lines");

endmodule

// >>> test/pcip_far_tgt.sv
// far-side pci target that answers the port's initiator cycles
`timescale 1ns/10ps
module pcip_far_tgt (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // resolved bus lines
    input  wire logic       frame_n,
    input  wire logic       irdy_n,
    input  wire logic [3:0] cbe_n,
    // behaviour and drive
    input  wire logic       claim,
    input  wire logic [2:0] waits,
    output logic            devsel_n,
    output logic            trdy_n,
    output logic            oe,
    output logic            ad_oe
);
    logic       rd_q;
    logic       fr_q;
    logic [2:0] cnt_q;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            {devsel_n, trdy_n, oe, ad_oe, rd_q, fr_q, cnt_q} <= 9'h188;
        end else begin
            fr_q <= frame_n;
            if (fr_q && !frame_n && claim && !oe) begin
                rd_q <= !cbe_n[0];
                oe <= 1'b1;
                devsel_n <= 1'b0;
                cnt_q <= waits;
            end else if (!devsel_n && !trdy_n && !irdy_n) begin
                {devsel_n, trdy_n, ad_oe} <= 3'h6;
            end else if (!devsel_n && cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end else if (!devsel_n) begin
                trdy_n <= 1'b0;
                ad_oe <= rd_q;
            end else begin
                oe <= 1'b0;
            end
        end
    end
endmodule

// >>> test/tb_top.sv
// testbench for the pci initiator/target port
`timescale 1ns/10ps
module tb_top;
    localparam logic [31:0] F_RD = 32'h1234_5678;
    localparam logic [15:0] CLAIMS = 16'hDCC0;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        gnt_n = 1'b0, idsel = 1'b0, ini_req = 1'b0, ini_lock = 1'b0;
    logic        m_frame = 1'b1, m_irdy = 1'b1, m_oe = 1'b0, m_adoe = 1'b0;
    logic        o_lock = 1'b1, claim = 1'b0;
    logic [2:0]  f_waits = 3'h0;
    logic [3:0]  ini_cmd = 4'h0, ini_be_n = 4'hF, m_cbe = 4'hF;
    logic [31:0] ini_addr = 32'h0, ini_wdata = 32'h0, m_ad = 32'h0;
    logic [31:0] dram_base = 32'h0001_0000, dram_limit = 32'h0001_FFFF;
    logic [31:0] tgt_rdata = 32'h9ABC_DEF0, idle_q = 32'h5A5A_0F0F;
    logic [31:0] ad_in, ad_out_q, ini_rdata_q, tgt_addr_q, tgt_wdata_q;
    logic [3:0]  cbe_n_in, cbe_n_out_q, tgt_be_n_q;
    logic        ad_oe_q, cbe_n_oe_q, frame_n_in, frame_n_out_q, frame_n_oe_q;
    logic        irdy_n_in, irdy_n_out_q, irdy_n_oe_q, trdy_n_in, trdy_n_out_q, trdy_n_oe_q;
    logic        devsel_n_in, devsel_n_out_q, devsel_n_oe_q, par_out_q, par_oe_q;
    logic        bus_lock_n_in, bus_lock_n_out_q, bus_lock_n_oe_q, ini_busy_q, ini_done_q;
    logic        ini_abort_q, ini_lock_own_q, tgt_wr_q, tgt_rd_q, tgt_cfg_q;
    logic        f_devsel, f_trdy, f_oe, f_adoe;
    int          bad_count = 0, compares = 0;
    // pulled-up controls are wired-and; an undriven ad/cbe keeps changing
    assign frame_n_in = (frame_n_out_q | ~frame_n_oe_q) & m_frame;
    assign irdy_n_in = (irdy_n_out_q | ~irdy_n_oe_q) & m_irdy;
    assign trdy_n_in = (trdy_n_out_q | ~trdy_n_oe_q) & (f_trdy | ~f_oe);
    assign devsel_n_in = (devsel_n_out_q | ~devsel_n_oe_q) & (f_devsel | ~f_oe);
    assign bus_lock_n_in = (bus_lock_n_out_q | ~bus_lock_n_oe_q) & o_lock;
    assign cbe_n_in = cbe_n_oe_q ? cbe_n_out_q : m_oe ? m_cbe : idle_q[3:0];
    assign ad_in = ad_oe_q ? ad_out_q : f_adoe ? F_RD : m_adoe ? m_ad : idle_q;
    always @(posedge clk_sys) idle_q <= ~idle_q;
    pcip_port uut (.*);
    pcip_far_tgt far (.clk_sys(clk_sys), .sys_rst(sys_rst), .frame_n(frame_n_in),
        .irdy_n(irdy_n_in), .cbe_n(cbe_n_in), .claim(claim), .waits(f_waits),
        .devsel_n(f_devsel), .trdy_n(f_trdy), .oe(f_oe), .ad_oe(f_adoe));
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic test_done();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(logic ok, string m);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic lim(int n, int m);
        if (n >= m) chk(1'b0, "wait ran out");
        if (n >= m) test_done();
    endtask
    task automatic t_ini(logic [3:0] c, logic [31:0] a, logic [31:0] d, logic [3:0] be, logic cl);
        int n;
        ini_cmd = c;
        ini_addr = a;
        ini_wdata = d;
        ini_be_n = be;
        claim = cl;
        ini_req = 1'b1;
        for (n = 0; n < 12 && frame_n_in !== 1'b0; n++) tick();
        lim(n, 12);
        ini_req = 1'b0;
        chk(ad_in === a && cbe_n_in === c
            && frame_n_oe_q === 1'b1, "address");
        tick();
        chk(irdy_n_in === 1'b0 && cbe_n_in === be && frame_n_in === 1'b1, "data");
        chk(par_oe_q === 1'b1 && par_out_q === ^{a, c}, "parity");
        chk(!c[0] || ad_in === d, "write data");
        for (n = 0; n < 12 && ini_done_q !== 1'b1; n++) tick();
        lim(n, 12);
        chk(ini_abort_q === !cl && (!cl || c[0] || ini_rdata_q === F_RD), "end");
        claim = 1'b0;
        tick(2);
        $display("initiator cycle %h done", c);
    endtask
    task automatic t_tgt(logic [3:0] c, logic [31:0] a, logic sel, logic exp);
        int n;
        idsel = sel;
        m_oe = 1'b1;
        m_adoe = 1'b1;
        m_frame = 1'b0;
        m_ad = a;
        m_cbe = c;
        tick();
        m_frame = 1'b1;
        m_irdy = 1'b0;
        m_cbe = 4'h6;
        m_ad = {28'h00C_0DE0, c};
        m_adoe = c[0];
        tick();
        chk(devsel_n_in === !exp, "device select");
        for (n = 0; n < 6 && exp && trdy_n_in !== 1'b0; n++) tick();
        lim(n, 6);
        if (exp) chk(tgt_cfg_q === (c[3:1] == 3'h5) && tgt_addr_q === a
            && (c[0] || ad_in === tgt_rdata), "kind");
        tick();
        if (exp) chk(c[0] ? tgt_wr_q && tgt_wdata_q === m_ad && tgt_be_n_q === 4'h6
            : tgt_rd_q, "beat");
        m_irdy = 1'b1;
        m_adoe = 1'b0;
        m_oe = 1'b0;
        tick(3);
        $display("target cycle %h done", c);
    endtask
    task automatic t_burst();
        m_oe = 1'b1;
        m_adoe = 1'b1;
        m_frame = 1'b0;
        m_ad = 32'h0001_0020;
        m_cbe = 4'h7;
        tick();
        m_irdy = 1'b0;
        m_cbe = 4'h0;
        m_ad = 32'h1111_0001;
        tick(2);
        chk(tgt_wr_q === 1'b1 && tgt_wdata_q === m_ad && tgt_be_n_q === 4'h0
            && tgt_addr_q === 32'h0001_0020, "first beat");
        // last data phase: framing high while initiator-ready stays low
        m_frame = 1'b1;
        m_cbe = 4'h3;
        m_ad = 32'h2222_0002;
        tick(2);
        chk(tgt_wr_q === 1'b1 && tgt_wdata_q === m_ad && tgt_be_n_q === 4'h3
            && tgt_addr_q === 32'h0001_0024, "second beat");
        m_irdy = 1'b1;
        m_adoe = 1'b0;
        m_oe = 1'b0;
        tick(3);
        $display("burst write done");
    endtask
    task automatic t_lock();
        ini_lock = 1'b1;
        o_lock = 1'b0;
        ini_req = 1'b1;
        tick(6);
        chk(ini_busy_q === 1'b0, "lock refused");
        o_lock = 1'b1;
        t_ini(4'h7, 32'h0000_0400, 32'h1357_9BDF, 4'h0, 1'b1);
        chk(ini_lock_own_q === 1'b1 && bus_lock_n_in === 1'b0, "lock owned");
        t_ini(4'h6, 32'h0000_0404, 32'h0, 4'h0, 1'b1);
        ini_lock = 1'b0;
        tick(4);
        chk(ini_lock_own_q === 1'b0 && bus_lock_n_in === 1'b1, "lock freed");
        $display("lock test done");
    endtask
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        tick(8);
        sys_rst = 1'b0;
        tick();
        t_ini(4'hF, 32'h0000_0100, 32'hA5A5_0001, 4'h0, 1'b1);
        f_waits = 3'h2;
        t_ini(4'h6, 32'h0000_0200, 32'h0, 4'h3, 1'b1);
        t_ini(4'h7, 32'h0000_0300, 32'h0, 4'h0, 1'b0);
        t_lock();
        for (int c = 0; c < 16; c++) t_tgt(c[3:0], 32'h0001_0010, 1'b1, CLAIMS[c]);
        t_tgt(4'h7, 32'h0002_0000, 1'b1, 1'b0);
        t_tgt(4'hA, 32'h0001_0010, 1'b0, 1'b0);
        t_burst();
        test_done();
    end
endmodule
